// ---- logic/emsc_chain.sv ----
// Behaviour
// [R01] Two voltage/current pairs, two power paths
// [R02] Bitstreams sampled at clock over eight
// [R03] Sinc3 decimators give 24-bit words, clock/1024
// [R04] Droop IIR on by default, bypass bit
// [R05] Nine-bit fine delay on current channel
// [R06] Two-bit coarse delay, current or voltage
// [R07] Longer current delay gives negative voltage delay
// [R08] Combined delay spans plus/minus one word period; code reaches nearly two words each way
// [R09] Per-channel offset and gain correction
// [R10] Per-path selectable DC-blocking high-pass
// [R11] Host pairs lone high-pass with equalizer
// [R12] Host enables high-pass on both for AC
// [R13] Optional integrator on each current channel
// [R14] Results average N output-rate samples
// [R15] Fixed-count default, mode bit selects synchronized; code needs the auto-frequency bit set too
// [R16] Sample count resets to 4000, host keeps >=100
// [R17] Synchronized N follows measured half cycles
// [R18] Host keeps default count, sets auto frequency
// [R19] Host leaves count alone while converting
// [R20] RMS is root of mean square
// [R21] Active power is mean of v times i
// [R22] Quadrature voltage integrator, ratio-corrected gain
// [R23] Line ratio register defaults to 0.0125
// [R24] Accumulators restart each interval, results publish together
`timescale 1ns/1ps
`default_nettype none
`include "emsc_map.svh"

module emsc_chain #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_rst_n,
    // Modulator bitstreams: 0 V1, 1 I1, 2 V2, 3 I2
    input  wire logic [3:0]            i_mod_bits,
    // Register port
    input  wire emsc_pkg::emsc_bus_req_t i_bus,
    output logic [31:0]                o_rd_data,
    // Low-rate results published
    output logic                       o_update
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    // Square sums are 46 bits; wider counts would overflow 64-bit sums
    if (CNT_W < 12 || CNT_W > 18) begin : g_chk
        $error("emsc_chain: CNT_W must be 12..18");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [`EMSC_PH_W-1:0]     ph;
        logic [3:0][2:0][31:0]     integ;
        logic [3:0][2:0][31:0]     cdly;
        logic [3:0][23:0]          raw;
        logic [3:0][1:0][23:0]     hist;
        logic [3:0][23:0]          droop_y;
        logic [3:0][23:0]          dc_est;
        logic [3:0][23:0]          dc_slow;
        logic [1:0][31:0]          int_acc;
        logic [1:0][39:0]          vq_acc;
        logic [3:0][23:0]          inst;
        logic [7:0][63:0]          sums;
        logic [7:0][63:0]          snap;
        logic [CNT_W-1:0]          snap_n;
        logic [CNT_W-1:0]          wc;
        logic [CNT_W-1:0]          spc;
        logic [CNT_W-1:0]          hc;
        logic [CNT_W-1:0]          n_meas;
        logic                      v_sign;
        emsc_pkg::emsc_calc_t      calc;
        logic [2:0]                idx;
        logic [6:0]                step;
        logic                      neg;
        logic [63:0]               quo;
        logic [CNT_W:0]            rem;
        logic [23:0]               root;
        logic [7:0][23:0]          pend;
        logic [7:0][23:0]          res;
        logic [`EMSC_CFG_W-1:0]    cfg;
        logic [1:0][10:0]          phase_delay_setting;
        logic [CNT_W-1:0]          averaging_sample_count;
        logic [CNT_W-1:0]          half_cycle_count;
        logic [23:0]               line_ratio;
        logic [3:0][23:0]          offs;
        logic [3:0][23:0]          gain;
        logic [15:0]               upd_cnt;
        logic [31:0]               rd_data;
        logic                      update;
    } emsc_state_t;

    emsc_state_t st_r;
    emsc_state_t st_nxt;
    logic        rst_meta_r;
    logic        rst_sync_r;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Clamp a wide signed value into a 24-bit sample
    function automatic logic [23:0] sat24(input logic signed [71:0] v);
        if (v > 72'sh7FFFFF) begin
            sat24 = 24'h7FFFFF;
        end else if (v < -72'sh800000) begin
            sat24 = 24'h800000;
        end else begin
            sat24 = v[23:0];
        end
    endfunction

    // First-order tracking step: y + (x - y) / 1024
    function automatic logic [23:0] track(input logic [23:0] y, input logic [23:0] x);
        logic signed [25:0] d;
        d = 26'(signed'(x)) - 26'(signed'(y));
        track = sat24(72'(signed'(y)) + 72'(d >>> 10));
    endfunction

    // Widen a 24-bit sample for arithmetic
    function automatic logic signed [71:0] wide(input logic [23:0] x);
        wide = 72'(signed'(x));
    endfunction

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    // Release is synchronised so that no flop leaves reset a cycle early
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        emsc_state_t         s;
        logic [9:0]          off;
        logic                stick;
        logic                wtick;
        logic [31:0]         c1;
        logic [31:0]         c2;
        logic [31:0]         c3;
        logic [1:0]          crs;
        logic [1:0]          dsel;
        logic [23:0]         x;
        logic [23:0]         y;
        logic [23:0]         t;
        logic [23:0]         f;
        logic signed [71:0]  w;
        logic signed [71:0]  vq;
        logic [23:0]         vqs;
        logic [1:0]          fsel;
        logic                proc;
        logic                last;
        logic                sync;
        logic [CNT_W-1:0]    n_eff;
        logic [CNT_W:0]      remt;
        logic [23:0]         trial;
        logic                done;
        s     = st_r;
        off   = '0;
        stick = 1'b0;
        wtick = 1'b0;
        c1    = '0;
        c2    = '0;
        c3    = '0;
        crs   = '0;
        dsel  = '0;
        x     = '0;
        y     = '0;
        t     = '0;
        f     = '0;
        w     = '0;
        vq    = '0;
        vqs   = '0;
        fsel  = '0;
        proc  = (st_r.ph == `EMSC_PROC_PH);
        last  = 1'b0;
        sync  = st_r.cfg[`EMSC_B_AVERAGING_MODE_SELECT] && st_r.cfg[`EMSC_B_AUTO_FREQ];
        n_eff = sync ? st_r.n_meas : st_r.averaging_sample_count;
        remt  = '0;
        trial = '0;
        done  = 1'b0;
        s.update = 1'b0;
        s.ph     = st_r.ph + 10'h001;

        // Decimation; current channels take their ticks late by the fine delay
        for (int c = 0; c < 4; c++) begin
            off   = c[0] ? {st_r.phase_delay_setting[c>>1][8:0], 1'b0} : 10'h000; // [R05]
            stick = (st_r.ph[2:0] == off[2:0]);                                    // [R02]
            wtick = (st_r.ph == off);
            if (stick) begin
                s.integ[c][0] = st_r.integ[c][0] + (i_mod_bits[c] ? 32'h00000001 : 32'hFFFFFFFF);
                s.integ[c][1] = st_r.integ[c][1] + s.integ[c][0];
                s.integ[c][2] = st_r.integ[c][2] + s.integ[c][1];
            end
            if (wtick) begin
                // Comb at 1/128 of the input rate; full scale is 2^21
                c1 = st_r.integ[c][2] - st_r.cdly[c][0];
                c2 = c1 - st_r.cdly[c][1];
                c3 = c2 - st_r.cdly[c][2];
                s.cdly[c] = {c2, c1, st_r.integ[c][2]};
                s.raw[c]  = {c3[22:0], 1'b0};                                       // [R03]
            end
        end

        // Word-rate processing, one common instant after every channel latched
        if (proc) begin
            for (int c = 0; c < 4; c++) begin
                crs = st_r.phase_delay_setting[c>>1][`EMSC_B_COARSE +: 2];
                // Code 1 delays current; 2 and 3 delay voltage by one or two words
                if (c[0]) begin
                    dsel = (crs == 2'h1) ? 2'h1 : 2'h0;                              // [R06]
                end else begin
                    dsel = (crs == 2'h2) ? 2'h1 : ((crs == 2'h3) ? 2'h2 : 2'h0);     // [R06]
                end
                // Current delay above voltage delay acts as negative voltage delay
                x = (dsel == 2'h0) ? st_r.raw[c] : st_r.hist[c][dsel-2'h1];          // [R07] [R08]
                s.hist[c] = {st_r.hist[c][0], st_r.raw[c]};

                // Droop boost: unity at DC, lifted toward Nyquist
                y = sat24(wide(x) + (wide(x) >>> 4) - (wide(st_r.droop_y[c]) >>> 4));
                s.droop_y[c] = st_r.cfg[`EMSC_B_DROOP_BYP] ? x : y;                 // [R04]

                // Offset then gain, gain 0x400000 is unity
                w = (wide(s.droop_y[c]) + wide(st_r.offs[c])) * 72'(st_r.gain[c]);
                t = sat24(w >>> 22);                                                 // [R09]

                // DC estimate; equalizer adds back its slow lag to copy the phase
                s.dc_est[c]  = track(st_r.dc_est[c], t);
                s.dc_slow[c] = track(st_r.dc_slow[c], s.dc_est[c]);
                fsel = st_r.cfg[`EMSC_B_FILT0 + 2*c +: 2];
                if (fsel == `EMSC_FLT_HPF) begin
                    f = sat24(wide(t) - wide(s.dc_est[c]));                          // [R10]
                end else if (fsel == `EMSC_FLT_PMF) begin
                    f = sat24(wide(t) - wide(s.dc_est[c]) + wide(s.dc_slow[c]));
                end else begin
                    f = t;
                end

                // Leaky integrator undoes a coil's lead and slope
                if (c[0] && st_r.cfg[`EMSC_B_INT_EN0 + (c>>1)]) begin
                    w = 72'(signed'(st_r.int_acc[c>>1]));
                    w = w - (w >>> 8) + (wide(f) >>> 3);
                    s.int_acc[c>>1] = w[31:0];                                       // [R13]
                    f = sat24(w);
                end
                s.inst[c] = f;
                s.sums[c] = st_r.sums[c] + 64'(wide(f) * wide(f));                    // [R20]
            end

            // Each pair forms its own active and reactive products
            for (int p = 0; p < 2; p++) begin
                w = 72'(signed'(st_r.vq_acc[p]));
                w = w - (w >>> 10) + wide(s.inst[2*p]);
                s.vq_acc[p] = w[39:0];
                // Scale by line ratio and 2*pi (about 6.25) for unity gain
                // Signed product so the shift keeps the sign of negative voltages
                vq = (w * signed'(72'(st_r.line_ratio))) >>> 24;
                vqs = sat24((vq <<< 2) + (vq <<< 1) + (vq >>> 2));                   // [R22] [R23]
                s.sums[4+p] = st_r.sums[4+p]
                            + 64'(wide(s.inst[2*p]) * wide(s.inst[2*p+1]));         // [R01] [R21]
                s.sums[6+p] = st_r.sums[6+p] + 64'(wide(vqs) * wide(s.inst[2*p+1])); // [R22]
            end

            // Half-cycle span of V1 measured in words
            s.v_sign = s.inst[0][23];
            if (s.v_sign != st_r.v_sign) begin
                if (st_r.hc + 1'b1 >= st_r.half_cycle_count) begin
                    s.n_meas = st_r.spc + 1'b1;                                       // [R17]
                    s.hc     = '0;
                    s.spc    = '0;
                end else begin
                    s.hc  = st_r.hc + 1'b1;
                    s.spc = st_r.spc + 1'b1;
                end
            end else if (st_r.spc != '1) begin
                s.spc = st_r.spc + 1'b1;
            end

            // Interval end: snapshot, clear, start the result engine
            last = ({1'b0, st_r.wc} + 1'b1 >= {1'b0, n_eff});                         // [R14] [R15]
            if (last) begin
                s.snap   = s.sums;
                s.snap_n = st_r.wc + 1'b1;
                s.sums   = '0;                                                        // [R24]
                s.wc     = '0;
                s.idx    = '0;
                s.calc   = emsc_pkg::EMSC_LOAD;
            end else begin
                s.wc = st_r.wc + 1'b1;
            end
        end

        // Result engine: divide by N, then root for the RMS entries
        unique case (st_r.calc)
            emsc_pkg::EMSC_IDLE: begin
            end
            emsc_pkg::EMSC_LOAD: begin
                s.neg  = st_r.snap[st_r.idx][63];
                s.quo  = s.neg ? (~st_r.snap[st_r.idx] + 64'h1) : st_r.snap[st_r.idx];
                s.rem  = '0;
                s.step = '0;
                s.calc = emsc_pkg::EMSC_DIV;
            end
            emsc_pkg::EMSC_DIV: begin
                remt  = {st_r.rem[CNT_W-1:0], st_r.quo[63]};
                s.quo = {st_r.quo[62:0], 1'b0};
                if (remt >= {1'b0, st_r.snap_n}) begin
                    remt     = remt - {1'b0, st_r.snap_n};
                    s.quo[0] = 1'b1;
                end
                s.rem  = remt;
                s.step = st_r.step + 7'h01;
                if (st_r.step == 7'h3F) begin
                    s.step = '0;
                    if (!st_r.idx[2]) begin
                        s.root = '0;
                        s.calc = emsc_pkg::EMSC_SQRT;
                    end else begin
                        // Product mean carries 46 fractional bits; keep the top 24
                        f = s.quo[46:23];
                        s.pend[st_r.idx] = st_r.neg ? (~f + 24'h1) : f;                // [R21]
                        done = 1'b1;
                    end
                end
            end
            emsc_pkg::EMSC_SQRT: begin
                trial = st_r.root | (24'h800000 >> st_r.step);
                if (48'(trial) * 48'(trial) <= st_r.quo[47:0]) begin
                    s.root = trial;                                                   // [R20]
                end
                s.step = st_r.step + 7'h01;
                if (st_r.step == 7'h17) begin
                    s.pend[st_r.idx] = s.root;
                    done = 1'b1;
                end
            end
        endcase
        if (done) begin
            if (st_r.idx == 3'h7) begin
                s.res     = s.pend;                                                   // [R24]
                s.update  = 1'b1;
                s.upd_cnt = st_r.upd_cnt + 16'h0001;
                s.calc    = emsc_pkg::EMSC_IDLE;
            end else begin
                s.idx  = st_r.idx + 3'h1;
                s.calc = emsc_pkg::EMSC_LOAD;
            end
        end

        // Register writes; result words are read-only
        if (i_bus.wr) begin
            case (i_bus.addr)
                `EMSC_A_CONFIG:     s.cfg = i_bus.wdata[`EMSC_CFG_W-1:0];
                `EMSC_A_PHASE0:     s.phase_delay_setting[0] = i_bus.wdata[10:0];
                `EMSC_A_PHASE1:     s.phase_delay_setting[1] = i_bus.wdata[10:0];
                `EMSC_A_SAMPLE_CNT: s.averaging_sample_count = i_bus.wdata[CNT_W-1:0];
                `EMSC_A_HALF_CYC:   s.half_cycle_count = i_bus.wdata[CNT_W-1:0];
                `EMSC_A_LINE_RATIO: s.line_ratio = i_bus.wdata[23:0];
                default: begin
                    if (i_bus.addr[5:2] == 4'h2) begin
                        s.offs[i_bus.addr[1:0]] = i_bus.wdata[23:0];
                    end else if (i_bus.addr[5:2] == 4'h3) begin
                        s.gain[i_bus.addr[1:0]] = i_bus.wdata[23:0];
                    end
                end
            endcase
        end

        // Register reads, answered in the next cycle; unmapped reads zero
        s.rd_data = '0;
        if (i_bus.rd) begin
            case (i_bus.addr)
                `EMSC_A_CONFIG:     s.rd_data = 32'(st_r.cfg);
                `EMSC_A_PHASE0:     s.rd_data = 32'(st_r.phase_delay_setting[0]);
                `EMSC_A_PHASE1:     s.rd_data = 32'(st_r.phase_delay_setting[1]);
                `EMSC_A_SAMPLE_CNT: s.rd_data = 32'(st_r.averaging_sample_count);
                `EMSC_A_HALF_CYC:   s.rd_data = 32'(st_r.half_cycle_count);
                `EMSC_A_LINE_RATIO: s.rd_data = 32'(st_r.line_ratio);
                `EMSC_A_STATUS:     s.rd_data = {14'h0000, st_r.calc, st_r.upd_cnt};
                `EMSC_A_EFF_N:      s.rd_data = 32'(n_eff);
                default: begin
                    if (i_bus.addr[5:2] == 4'h2) begin
                        s.rd_data = {8'h00, st_r.offs[i_bus.addr[1:0]]};
                    end else if (i_bus.addr[5:2] == 4'h3) begin
                        s.rd_data = {8'h00, st_r.gain[i_bus.addr[1:0]]};
                    end else if (i_bus.addr[5:3] == 3'h2) begin
                        s.rd_data = {8'h00, st_r.res[i_bus.addr[2:0]]};
                    end else if (i_bus.addr[5:2] == 4'h6) begin
                        s.rd_data = {8'h00, st_r.inst[i_bus.addr[1:0]]};
                    end
                end
            endcase
        end
        st_nxt = s;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            st_r                        <= '0;
            st_r.averaging_sample_count <= CNT_W'(`EMSC_RST_SAMPLE);                 // [R16]
            st_r.n_meas                 <= CNT_W'(`EMSC_RST_SAMPLE);
            st_r.half_cycle_count       <= CNT_W'(`EMSC_RST_HALF_CYC);
            st_r.line_ratio             <= `EMSC_RST_RATIO;                           // [R23]
            st_r.gain                   <= {4{`EMSC_RST_GAIN}};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from state flops
    assign o_rd_data = st_r.rd_data;
    assign o_update  = st_r.update;

endmodule
`default_nettype wire

// ---- logic/emsc_map.svh ----
`ifndef EMSC_MAP_SVH
`define EMSC_MAP_SVH

// Register word addresses
`define EMSC_A_CONFIG      6'h00
`define EMSC_A_PHASE0      6'h01
`define EMSC_A_PHASE1      6'h02
`define EMSC_A_SAMPLE_CNT  6'h03
`define EMSC_A_HALF_CYC    6'h04
`define EMSC_A_LINE_RATIO  6'h05
`define EMSC_A_STATUS      6'h06
`define EMSC_A_EFF_N       6'h07
`define EMSC_A_OFFSET0     6'h08
`define EMSC_A_GAIN0       6'h0C
`define EMSC_A_RMS0        6'h10
`define EMSC_A_PAVG0       6'h14
`define EMSC_A_QAVG0       6'h16
`define EMSC_A_INST0       6'h18

// Configuration word fields
`define EMSC_B_DROOP_BYP   0
`define EMSC_B_AVERAGING_MODE_SELECT    1
`define EMSC_B_AUTO_FREQ   2
`define EMSC_B_INT_EN0     3
`define EMSC_B_FILT0       5
`define EMSC_CFG_W         13

// Phase delay setting fields
`define EMSC_B_FINE        0
`define EMSC_B_COARSE      9

// Filter select codes
`define EMSC_FLT_HPF       2'h1
`define EMSC_FLT_PMF       2'h2

// Reset values
`define EMSC_RST_SAMPLE    4000
`define EMSC_RST_HALF_CYC  100
`define EMSC_RST_RATIO     24'h033333
`define EMSC_RST_GAIN      24'h400000

// Timing: input sampling every 8 clocks, one output word every 1024 clocks
`define EMSC_PH_W          10
`define EMSC_PROC_PH       10'h3FF

`endif

// ---- logic/emsc_pkg.sv ----
`default_nettype none
package emsc_pkg;

    // Register port request, one cycle per access
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [5:0]  addr;
        logic [31:0] wdata;
    } emsc_bus_req_t;

    // Low-rate result engine
    typedef enum logic [1:0] {
        EMSC_IDLE,
        EMSC_LOAD,
        EMSC_DIV,
        EMSC_SQRT
    } emsc_calc_t;

endpackage
`default_nettype wire

// ---- test/emsc_mod_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module emsc_mod_model (
    // Clock, reset, ones density per channel in eighths
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic [15:0] i_dens,
    // Bitstreams V1 I1 V2 I2
    output logic [3:0]       o_bits
);
logic [2:0]  div_r;
logic [11:0] acc_r;
// First-order loop; pattern period divides 128 so words come out exact
always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        div_r <= 3'h0;
        acc_r <= 12'h000;
        o_bits <= 4'h0;
    end else begin
        div_r <= div_r + 3'h1;
        if (div_r == 3'h0) begin
            for (int c = 0; c < 4; c++) begin
                {o_bits[c], acc_r[3*c+:3]} <= {1'b0, acc_r[3*c+:3]} + i_dens[4*c+:4];
            end
        end
    end
end
endmodule
`default_nettype wire

// ---- test/emsc_props.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "emsc_map.svh"
module emsc_props #(
    parameter int CNT_W = 16
) (
    // Watched ports of the chain
    input wire logic                    i_sys_clk,
    input wire logic                    i_rst_n,
    input wire logic [3:0]              i_mod_bits,
    input wire emsc_pkg::emsc_bus_req_t i_bus,
    input wire logic [31:0]             o_rd_data,
    input wire logic                    o_update
);
// ----
// Port relations
// ----
default clocking @(posedge i_sys_clk); endclocking
default disable iff (!i_rst_n);
// Cycles since the last publish; saturates so it never wraps
logic [10:0] gap_r;
always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) gap_r <= 11'h000;
    else gap_r <= o_update ? 11'h000 : gap_r + {10'h000, ~&gap_r};
end
// Write of the count, then a read of it
sequence s_cnt_wr; i_bus.wr && i_bus.addr == `EMSC_A_SAMPLE_CNT; endsequence
sequence s_cnt_rd; i_bus.rd && i_bus.addr == `EMSC_A_SAMPLE_CNT; endsequence
chk_rd_idle: assert property (!$past(i_bus.rd) |-> o_rd_data == 32'h0)
    else $error("read data outside its slot");
chk_upd_pulse: assert property (o_update |=> !o_update)
    else $error("publish pulse too long");
chk_upd_gap: assert property (o_update |-> gap_r > 11'h3E8)
    else $error("publish interval shorter than a word");
chk_cfg_width: assert property (i_bus.rd && i_bus.addr == `EMSC_A_CONFIG
    |=> (o_rd_data >> `EMSC_CFG_W) == 32'h0) else $error("config upper bits set");
chk_phase_width: assert property (i_bus.rd && (i_bus.addr == `EMSC_A_PHASE0
    || i_bus.addr == `EMSC_A_PHASE1)
    |=> o_rd_data[31:11] == 21'h0) else $error("phase field too wide");
chk_rms_width: assert property (i_bus.rd && i_bus.addr[5:2] == 4'h4
    |=> o_rd_data[31:24] == 8'h00) else $error("rms above 24 bits");
chk_unmapped_zero: assert property (i_bus.rd && i_bus.addr >= 6'h1C
    |=> o_rd_data == 32'h0) else $error("unmapped read not zero");
chk_cnt_readback: assert property (s_cnt_wr ##1 s_cnt_rd
    |=> o_rd_data == ($past(i_bus.wdata, 2) & ((32'h1 << CNT_W) - 1)))
    else $error("sample count readback wrong");
endmodule
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "emsc_map.svh"
module tb;
// ----
// Stimulus and checking
// ----
typedef struct packed {logic [5:0] a; logic [31:0] lo; logic [31:0] hi;} emsc_exp_t;
logic                    i_sys_clk = 1'b0;
logic                    i_rst_n = 1'b0;
logic [3:0]              mod_bits;
logic [31:0]             o_rd_data;
logic                    o_update;
logic [15:0]             dens;
logic [31:0]             seed = 32'h799BFEE6;
logic [31:0]             v;
logic                    rd_seen = 1'b0;
emsc_pkg::emsc_bus_req_t bus = '0;
emsc_exp_t               exp_q[$];
emsc_exp_t               e;
int                      errors = 0;
int                      check_count = 0;
int                      cyc = 0;
always #25 i_sys_clk = ~i_sys_clk;
emsc_mod_model u_mod (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_dens(dens), .o_bits(mod_bits));
emsc_chain u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_mod_bits(mod_bits),
    .i_bus(bus), .o_rd_data(o_rd_data), .o_update(o_update));
function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
endfunction
// Steady word of a channel, scaled by a power of two gain
function automatic logic [31:0] lvl(input logic [3:0] dd, input int sh);
    logic signed [23:0] w;
    w = signed'({1'b0, dd}) - 24'sh4;
    return {8'h00, w <<< sh};
endfunction
task automatic op(input logic w, r, input logic [5:0] a, input logic [31:0] wd);
    @(posedge i_sys_clk);
    bus <= '{w, r, a, wd};
endtask
task automatic rd(input logic [5:0] a, input logic [31:0] lo, hi);
    exp_q.push_back('{a, lo, hi});
    op(1'b0, 1'b1, a, 32'h0);
endtask
task automatic idle(input int n);
    op(1'b0, 1'b0, 6'h00, 32'h0);
    repeat (n) @(posedge i_sys_clk);
endtask
task automatic check(input logic [31:0] seen, exp, input logic [5:0] a);
    check_count++;
    if (seen !== exp) begin
        errors++;
        $display("wrong value at address %h: expected %h, seen %h", a, exp, seen);
    end
endtask
task automatic conclude;
    $display("checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
endtask
// Read data stand only in the cycle after the strobe; a hang is cut off
always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (rd_seen) begin
        e = exp_q.pop_front();
        if (e.lo == e.hi) check(o_rd_data, e.lo, e.a);
        else check({31'h0, o_rd_data >= e.lo && o_rd_data <= e.hi}, 32'h1, e.a);
    end
    rd_seen <= bus.rd;
    if (cyc == 106000) begin
        errors++;
        conclude();
    end
end
initial begin
    // Pair 0 kept positive so averages have a known sign
    for (int c = 0; c < 4; c++) begin
        seed = xs(seed);
        dens[4*c+:4] = c < 2 ? 4'h5 + seed[1:0] : 4'(seed[3:0] % 4'h9);
    end
    repeat (20) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    rd(`EMSC_A_CONFIG, 32'h0, 32'h0);
    rd(`EMSC_A_SAMPLE_CNT, 32'hFA0, 32'hFA0);
    rd(`EMSC_A_HALF_CYC, 32'h64, 32'h64);
    rd(`EMSC_A_LINE_RATIO, 32'h33333, 32'h33333);
    rd(`EMSC_A_GAIN0, 32'h400000, 32'h400000);
    rd(`EMSC_A_OFFSET0, 32'h0, 32'h0);
    rd(6'h3F, 32'h0, 32'h0);
    idle(2);
    $display("test reset values done");
    // Filters stay off on both channels of each pair, count set before conversion
    op(1'b1, 1'b0, `EMSC_A_CONFIG, 32'h1);
    op(1'b1, 1'b0, `EMSC_A_SAMPLE_CNT, 32'h64);
    rd(`EMSC_A_SAMPLE_CNT, 32'h64, 32'h64);
    seed = xs(seed);
    op(1'b1, 1'b0, `EMSC_A_PHASE0, seed & 32'h7FF);
    rd(`EMSC_A_PHASE0, seed & 32'h7FF, seed & 32'h7FF);
    op(1'b1, 1'b0, `EMSC_A_STATUS, 32'hFFFF);
    rd(`EMSC_A_STATUS, 32'h0, 32'h0);
    idle(6144);
    for (int c = 0; c < 4; c++) rd(`EMSC_A_INST0 + 6'(c), lvl(dens[4*c+:4], 20),
        lvl(dens[4*c+:4], 20));
    op(1'b1, 1'b0, `EMSC_A_GAIN0 + 6'h3, 32'h200000);
    idle(4096);
    rd(`EMSC_A_INST0 + 6'h3, lvl(dens[15:12], 19), lvl(dens[15:12], 19));
    idle(1);
    $display("test words and gain done");
    for (int i = 0; i < 120000 && o_update !== 1'b1; i++) @(posedge i_sys_clk);
    v = lvl(dens[3:0], 20);
    rd(`EMSC_A_RMS0, v - v / 16, v + v / 64);
    v = (lvl(dens[3:0], 0) * lvl(dens[7:4], 0)) << 17;
    rd(`EMSC_A_PAVG0, v - v / 16, v + v / 64);
    rd(`EMSC_A_STATUS, 32'h1, 32'h1);
    rd(`EMSC_A_EFF_N, 32'h64, 32'h64);
    // Synchronized mode: V1 never changes sign, so N stays at its default
    op(1'b1, 1'b0, `EMSC_A_CONFIG, 32'h7);
    rd(`EMSC_A_EFF_N, 32'hFA0, 32'hFA0);
    idle(2);
    $display("test averages done");
    conclude();
end
endmodule
bind emsc_chain emsc_props #(.CNT_W(CNT_W)) u_props (.i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n), .i_mod_bits(i_mod_bits), .i_bus(i_bus),
    .o_rd_data(o_rd_data), .o_update(o_update));
`default_nettype wire
